// [verilog/aiss_pkg.sv]
`default_nettype none
package aiss_pkg;

   // Geometry
   localparam int AISS_DW = 16;
   localparam int AISS_AW = 4;
   localparam int AISS_NCH = 32;

   // Register offsets
   localparam logic [3:0] OFF_SAMPLE_SEL = 4'h0;
   localparam logic [3:0] OFF_BGREF_EN   = 4'h1;
   localparam logic [3:0] OFF_HIT_LOW    = 4'h2;
   localparam logic [3:0] OFF_SCAN_HIGH  = 4'h3;
   localparam logic [3:0] OFF_SCAN_LOW   = 4'h4;
   localparam logic [3:0] OFF_CHG_HIGH   = 4'h5;
   localparam logic [3:0] OFF_CHG_LOW    = 4'h6;
   localparam logic [3:0] OFF_CONTROL    = 4'h7;
   localparam logic [3:0] OFF_THR_LOW    = 4'h8;
   localparam logic [3:0] OFF_THR_HIGH   = 4'h9;
   localparam logic [3:0] OFF_IRQ_STAT   = 4'ha;
   localparam logic [3:0] OFF_IRQ_MASK   = 4'hb;

   // Reset value
   localparam logic [15:0] RST_WORD = 16'h0000;

   // Select fields
   localparam int NEG_B_LSB = 13;
   localparam int POS_B_LSB = 8;
   localparam int NEG_A_LSB = 5;
   localparam int POS_A_LSB = 0;

   // Input select codes
   localparam logic [2:0] NEG_AVSS     = 3'h0;
   localparam logic [4:0] POS_LAST_PIN = 5'h0d;
   localparam logic [4:0] POS_TEMP     = 5'h0e;
   localparam logic [4:0] POS_CHARGE   = 5'h0f;
   localparam logic [4:0] POS_BANDGAP  = 5'h1c;
   localparam logic [4:0] POS_AVSS     = 5'h1d;
   localparam logic [4:0] POS_AVDD     = 5'h1e;

   // Control register fields
   localparam int CTL_ASCAN_BIT = 15;
   localparam int CTL_ALT_BIT   = 10;
   localparam int CTL_CM_LSB    = 8;
   localparam int CTL_DIV_LSB   = 0;

   // Status bits
   localparam int IRQ_HIT  = 0;
   localparam int IRQ_WRAP = 1;
   localparam int IRQ_REF  = 2;

   // Variant and bit masks
   localparam int PKG_PINS   = 48;
   localparam int SMALL_PINS = 28;
   localparam int LARGE_PINS = 64;
   localparam logic [15:0] BGREF_MASK     = 16'h0007;
   localparam logic [15:0] HIT_MASK_FULL  = 16'h3fff;
   localparam logic [15:0] HIT_MASK_SMALL = 16'h03ff;
   localparam logic [15:0] SCANH_MASK     = 16'h1f00;
   localparam logic [15:0] CHGH_MASK_FULL = 16'h73ff;
   localparam logic [15:0] CHGH_MASK_BIG  = 16'h7300;
   localparam logic [15:0] CTL_MASK       = 16'h87ff;
   localparam logic [15:0] THR_MASK       = 16'h0fff;
   localparam logic [15:0] IRQ_MASK_ALL   = 16'h0007;

   // Timing
   localparam int MCLK_NS = 25;
   localparam int REF_STARTUP_NS = 1000000;
   localparam int REF_STARTUP_CYCLES = REF_STARTUP_NS / MCLK_NS;
   localparam int TCY_MCLKS = 2;

   typedef enum logic [1:0] {
      CM_LESS,
      CM_GREATER,
      CM_INSIDE,
      CM_OUTSIDE
   } aiss_cmp_mode_t;

endpackage
`default_nettype wire

// [verilog/aiss_scan_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface aiss_scan_if;
   logic [31:0] mask;
   logic [4:0]  cur;
   logic [4:0]  nxt;
   logic [4:0]  first;
   logic        wrap;
   modport req  (output mask, output cur, input nxt, input first,
                 input wrap);
   modport calc (input mask, input cur, output nxt, output first,
                 output wrap);
endinterface
`default_nettype wire

// [verilog/aiss_scan_next.sv]
`timescale 1ns/1ps
`default_nettype none
module aiss_scan_next
   import aiss_pkg::*;
(
   // Scan request and answer
   aiss_scan_if.calc scan
);
   logic above;

   // Downward walk ends on the lowest hit
   always_comb begin
      above = 1'b0;
      scan.nxt = scan.cur;
      scan.first = scan.cur;
      for (int i = AISS_NCH - 1; i >= 0; i--) begin
         if (scan.mask[i]) begin
            scan.first = 5'(i);
            if (5'(i) > scan.cur) begin
               scan.nxt = 5'(i);
               above = 1'b1;
            end
         end
      end
      if (!above) begin
         scan.nxt = scan.first; // see RULE19
      end
      scan.wrap = !above;
   end
endmodule
`default_nettype wire

// [verilog/aiss_conv_clk.sv]
`timescale 1ns/1ps
`default_nettype none
module aiss_conv_clk
   import aiss_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Divider setting and tick
   input  wire logic [7:0] divider,
   output var  logic       tad_tick
);
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic [8:0] limit;
   logic       at_limit;

   // Two mclk per instruction cycle
   assign limit = 9'(TCY_MCLKS * (int'(divider) + 1) - 1); // see RULE15
   assign at_limit = (cnt_reg >= limit);
   assign cnt_next = at_limit ? 9'h000 : cnt_reg + 9'h001;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 9'h000;
         tad_tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tad_tick <= at_limit;
      end
   end
endmodule
`default_nettype wire

// [verilog/aiss_regs.sv]
//Contract
//RULE1: B negative select, bits 15-13: 000 ground, others unimplemented.
//RULE2: B positive select, bits 12-8: codes 0..01101 route pins 0..13.
//RULE3: 1e/1d/1c pick supply/ground/band-gap, unbuffered; 10-1b reserved.
//RULE4: 0f charge unit, 0e temperature sensor; no pin connected.
//RULE5: Sample A selectors in low byte decode like the sample B ones.
//RULE6: Reference enables: bit2 converter, bit1 charge/comparator, bit0 core.
//RULE7: A requested reference comes up after ~1 ms unless enabled beforehand.
//RULE8: Hit register has fourteen channel flags; bits 15-14 read zero.
//RULE9: Compare mode 11 sets hit flag on buffer write or match.
//RULE10: Other compare modes set hit flag only on a match.
//RULE11: Smallest package lacks hit flags for channels 10 to 13.
//RULE12: Scan mask bit one includes its channel; low word 0-15, high 24-28.
//RULE13: Charge enable bit links the charge unit while its channel converts.
//RULE14: Largest package lacks charge enable bits for channels 16 to 23.
//RULE15: Conversion clock period is instruction cycle times divider plus one.
//RULE16: Alternate mode uses sample A then sample B; otherwise always sample A.
//RULE17: Compare mode: 00 less, 01 greater, 10 inside window, 11 outside.
//RULE18: Scan masks act only while auto-scan is on.
//RULE19: Auto-scan visits included channels ascending, wrapping to the lowest.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module aiss_regs
   import aiss_pkg::*;
#(
   parameter int REF_STARTUP_COUNT = REF_STARTUP_CYCLES
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [15:0] reg_rdata,
   // Converter core
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_result,
   // Reference requests from other modules
   input  wire logic [2:0]  ref_request,
   // Multiplexer routing
   output var  logic [4:0]  pos_code,
   output var  logic [2:0]  neg_code,
   output var  logic        route_ext_pin,
   output var  logic        route_avdd,
   output var  logic        route_avss,
   output var  logic        route_bandgap,
   output var  logic        route_charge_unit,
   output var  logic        route_temp_sensor,
   output var  logic        route_neg_avss,
   output var  logic        has_result_buf,
   output var  logic        sel_invalid,
   output var  logic        charge_unit_connect,
   // References and conversion clock
   output var  logic [2:0]  ref_enable,
   output var  logic [2:0]  ref_ready,
   output var  logic        tad_tick,
   output var  logic        scan_active,
   // Interrupt
   output var  logic        irq
);
   // Register state
   logic [15:0] sel_reg;
   logic [15:0] bgref_reg;
   logic [15:0] hit_reg;
   logic [15:0] scanh_reg;
   logic [15:0] scanl_reg;
   logic [15:0] chgh_reg;
   logic [15:0] chgl_reg;
   logic [15:0] ctl_reg;
   logic [15:0] thrl_reg;
   logic [15:0] thrh_reg;
   logic [15:0] stat_reg;
   logic [15:0] imask_reg;
   logic [15:0] hit_next;
   logic [15:0] stat_next;
   logic        sample_b_reg;
   logic [4:0]  scan_ch_reg;
   logic [2:0]  ref_ready_prev_reg;

   // Address decode
   logic        wr_sel;
   logic        wr_bgref;
   logic        wr_hit;
   logic        wr_scanh;
   logic        wr_scanl;
   logic        wr_chgh;
   logic        wr_chgl;
   logic        wr_ctl;
   logic        wr_thrl;
   logic        wr_thrh;
   logic        wr_stat;
   logic        wr_imask;
   logic [15:0] rd_mux;

   assign wr_sel   = reg_wr && (reg_addr == OFF_SAMPLE_SEL);
   assign wr_bgref = reg_wr && (reg_addr == OFF_BGREF_EN);
   assign wr_hit   = reg_wr && (reg_addr == OFF_HIT_LOW);
   assign wr_scanh = reg_wr && (reg_addr == OFF_SCAN_HIGH);
   assign wr_scanl = reg_wr && (reg_addr == OFF_SCAN_LOW);
   assign wr_chgh  = reg_wr && (reg_addr == OFF_CHG_HIGH);
   assign wr_chgl  = reg_wr && (reg_addr == OFF_CHG_LOW);
   assign wr_ctl   = reg_wr && (reg_addr == OFF_CONTROL);
   assign wr_thrl  = reg_wr && (reg_addr == OFF_THR_LOW);
   assign wr_thrh  = reg_wr && (reg_addr == OFF_THR_HIGH);
   assign wr_stat  = reg_wr && (reg_addr == OFF_IRQ_STAT);
   assign wr_imask = reg_wr && (reg_addr == OFF_IRQ_MASK);

   // Package variant masks
   logic [15:0] hit_mask;
   logic [15:0] chgh_mask;

   assign hit_mask = (PKG_PINS == SMALL_PINS) ? HIT_MASK_SMALL
      : HIT_MASK_FULL; // see RULE8 see RULE11
   assign chgh_mask = (PKG_PINS == LARGE_PINS) ? CHGH_MASK_BIG
                                               : CHGH_MASK_FULL; // see RULE14

   // Control fields
   logic           ascan_on;
   logic           alt_mode;
   aiss_cmp_mode_t cmp_mode;
   logic [7:0]     div_val;

   assign ascan_on = ctl_reg[CTL_ASCAN_BIT];
   assign alt_mode = ctl_reg[CTL_ALT_BIT];
   assign cmp_mode = aiss_cmp_mode_t'(ctl_reg[CTL_CM_LSB +: 2]);
   assign div_val  = ctl_reg[CTL_DIV_LSB +: 8];

   // Per-channel vectors
   logic [31:0] scan_vec;
   logic [31:0] chg_vec;

   assign scan_vec = {3'h0, scanh_reg[12:8], 8'h00, scanl_reg}; // see RULE12
   assign chg_vec = {1'b0, chgh_reg[14:12], 2'h0, chgh_reg[9:0],
                     chgl_reg}; // see RULE13

   // Scan order
   aiss_scan_if scan ();

   assign scan.mask = ascan_on ? scan_vec : 32'h0000_0000; // see RULE18
   assign scan.cur = scan_ch_reg;

   aiss_scan_next u_scan_next (
      .scan (scan.calc)
   );

   // Channel selection
   logic [4:0] pos_a;
   logic [4:0] pos_b;
   logic [2:0] neg_a;
   logic [2:0] neg_b;
   logic       use_b;
   logic       scan_live;
   logic [4:0] cur_pos;
   logic [2:0] cur_neg;

   assign pos_b = sel_reg[POS_B_LSB +: 5]; // see RULE2
   assign neg_b = sel_reg[NEG_B_LSB +: 3]; // see RULE1
   assign pos_a = sel_reg[POS_A_LSB +: 5]; // see RULE5
   assign neg_a = sel_reg[NEG_A_LSB +: 3]; // see RULE5
   assign use_b = alt_mode && sample_b_reg; // see RULE16
   assign scan_live = ascan_on && (scan_vec != 32'h0000_0000);
   assign cur_pos = scan_live ? scan_ch_reg : (use_b ? pos_b : pos_a);
   assign cur_neg = use_b ? neg_b : neg_a;

   // Input code decode
   logic dec_ext;
   logic dec_avdd;
   logic dec_avss;
   logic dec_bg;
   logic dec_charge;
   logic dec_temp;
   logic dec_neg_ok;
   logic dec_buf;

   assign dec_ext    = (cur_pos <= POS_LAST_PIN); // see RULE2
   assign dec_avdd   = (cur_pos == POS_AVDD); // see RULE3
   assign dec_avss   = (cur_pos == POS_AVSS); // see RULE3
   assign dec_bg     = (cur_pos == POS_BANDGAP); // see RULE3
   assign dec_charge = (cur_pos == POS_CHARGE); // see RULE4
   assign dec_temp   = (cur_pos == POS_TEMP); // see RULE4
   assign dec_neg_ok = (cur_neg == NEG_AVSS); // see RULE1
   // Only external pins own a result buffer
   assign dec_buf = dec_ext; // see RULE3

   // Threshold compare
   logic [11:0] thr_lo;
   logic [11:0] thr_hi;
   logic        below;
   logic        over;
   logic        match;

   assign thr_lo = thrl_reg[11:0];
   assign thr_hi = thrh_reg[11:0];
   assign below = (conv_result < thr_lo);
   assign over  = (conv_result > thr_hi);

   always_comb begin
      unique case (cmp_mode) // see RULE17
         CM_LESS:    match = below;
         CM_GREATER: match = (conv_result > thr_lo);
         CM_INSIDE:  match = !below && !over;
         CM_OUTSIDE: match = below || over;
      endcase
   end

   // Hit flag events
   logic        hit_cause;
   logic [15:0] hit_set;

   assign hit_cause = conv_done && dec_buf &&
      (match || (cmp_mode == CM_OUTSIDE)); // see RULE9 see RULE10
   assign hit_set = hit_cause ? (16'h0001 << cur_pos[3:0]) & hit_mask
                              : 16'h0000;
   // Hardware set wins over a same-cycle software write
   assign hit_next = (wr_hit ? (reg_wdata & hit_mask) : hit_reg)
                     | hit_set; // see RULE8

   // Reference warm-up counters
   logic [2:0] ref_on;
   logic [2:0] ref_done;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ref
         logic [15:0] warm_reg;
         assign ref_on[g] = bgref_reg[g] || ref_request[g]; // see RULE6
         assign ref_done[g] = ref_on[g] &&
                              (warm_reg >= 16'(REF_STARTUP_COUNT));
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               warm_reg <= 16'h0000;
            end else if (!ref_on[g]) begin
               warm_reg <= 16'h0000;
            end else if (!ref_done[g]) begin
               warm_reg <= warm_reg + 16'h0001; // see RULE7
            end
         end
      end
   endgenerate

   // Interrupt events
   logic [15:0] events;
   logic [15:0] stat_clr;

   assign events = {13'h0000,
                    |(ref_done & ~ref_ready_prev_reg),
                    conv_done && scan_live && scan.wrap,
                    |hit_set};
   assign stat_clr = wr_stat ? (reg_wdata & IRQ_MASK_ALL) : 16'h0000;
   assign stat_next = (stat_reg & ~stat_clr) | events;

   // Conversion clock
   aiss_conv_clk u_conv_clk (
      .mclk     (mclk),
      .rst      (rst),
      .divider  (div_val),
      .tad_tick (tad_tick)
   );

   // Read multiplexer
   always_comb begin
      unique case (reg_addr)
         OFF_SAMPLE_SEL: rd_mux = sel_reg;
         OFF_BGREF_EN:   rd_mux = bgref_reg;
         OFF_HIT_LOW:    rd_mux = hit_reg;
         OFF_SCAN_HIGH:  rd_mux = scanh_reg;
         OFF_SCAN_LOW:   rd_mux = scanl_reg;
         OFF_CHG_HIGH:   rd_mux = chgh_reg;
         OFF_CHG_LOW:    rd_mux = chgl_reg;
         OFF_CONTROL:    rd_mux = ctl_reg;
         OFF_THR_LOW:    rd_mux = thrl_reg;
         OFF_THR_HIGH:   rd_mux = thrh_reg;
         OFF_IRQ_STAT:   rd_mux = stat_reg;
         OFF_IRQ_MASK:   rd_mux = imask_reg;
         default:        rd_mux = 16'h0000;
      endcase
   end

   // Software registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel_reg   <= RST_WORD;
         bgref_reg <= RST_WORD;
         scanh_reg <= RST_WORD;
         scanl_reg <= RST_WORD;
         chgh_reg  <= RST_WORD;
         chgl_reg  <= RST_WORD;
         ctl_reg   <= RST_WORD;
         thrl_reg  <= RST_WORD;
         thrh_reg  <= RST_WORD;
         imask_reg <= RST_WORD;
      end else begin
         if (wr_sel)   sel_reg   <= reg_wdata;
         if (wr_bgref) bgref_reg <= reg_wdata & BGREF_MASK; // see RULE6
         if (wr_scanh) scanh_reg <= reg_wdata & SCANH_MASK; // see RULE12
         if (wr_scanl) scanl_reg <= reg_wdata;
         if (wr_chgh)  chgh_reg  <= reg_wdata & chgh_mask; // see RULE13
         if (wr_chgl)  chgl_reg  <= reg_wdata;
         if (wr_ctl)   ctl_reg   <= reg_wdata & CTL_MASK;
         if (wr_thrl)  thrl_reg  <= reg_wdata & THR_MASK;
         if (wr_thrh)  thrh_reg  <= reg_wdata & THR_MASK;
         if (wr_imask) imask_reg <= reg_wdata & IRQ_MASK_ALL;
      end
   end

   // Hardware-updated state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hit_reg <= RST_WORD;
         stat_reg <= RST_WORD;
         irq <= 1'b0;
         reg_rdata <= 16'h0000;
         ref_ready_prev_reg <= 3'h0;
      end else begin
         hit_reg <= hit_next;
         stat_reg <= stat_next;
         irq <= |(stat_next & imask_reg);
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
         ref_ready_prev_reg <= ref_done;
      end
   end

   // Sample and scan position
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sample_b_reg <= 1'b0;
         scan_ch_reg <= 5'h00;
      end else begin
         if (!alt_mode) begin
            sample_b_reg <= 1'b0; // see RULE16
         end else if (conv_done) begin
            sample_b_reg <= !sample_b_reg;
         end
         if (!scan_live) begin
            scan_ch_reg <= scan.first;
         end else if (conv_done || !scan_vec[scan_ch_reg]) begin
            scan_ch_reg <= scan.nxt; // see RULE19
         end
      end
   end

   // Routing outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pos_code <= 5'h00;
         neg_code <= 3'h0;
         route_ext_pin <= 1'b0;
         route_avdd <= 1'b0;
         route_avss <= 1'b0;
         route_bandgap <= 1'b0;
         route_charge_unit <= 1'b0;
         route_temp_sensor <= 1'b0;
         route_neg_avss <= 1'b0;
         has_result_buf <= 1'b0;
         sel_invalid <= 1'b0;
         charge_unit_connect <= 1'b0;
         ref_enable <= 3'h0;
         ref_ready <= 3'h0;
         scan_active <= 1'b0;
      end else begin
         pos_code <= cur_pos;
         neg_code <= cur_neg;
         route_ext_pin <= dec_ext;
         route_avdd <= dec_avdd;
         route_avss <= dec_avss;
         route_bandgap <= dec_bg;
         route_charge_unit <= dec_charge;
         route_temp_sensor <= dec_temp;
         route_neg_avss <= dec_neg_ok; // see RULE1
         has_result_buf <= dec_buf;
         // Reserved or unimplemented codes
         sel_invalid <= !(dec_ext || dec_avdd || dec_avss || dec_bg ||
            dec_charge || dec_temp) || !dec_neg_ok; // see RULE3
         charge_unit_connect <= chg_vec[cur_pos]; // see RULE13
         ref_enable <= ref_on;
         ref_ready <= ref_done;
         scan_active <= scan_live;
      end
   end
endmodule
`default_nettype wire

// [testbench/aiss_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module aiss_regs_props
   import aiss_pkg::*;
#(
   parameter int REF_STARTUP_COUNT = 8
)
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // Register port
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Routing
   input wire logic [4:0]  pos_code,
   input wire logic [2:0]  neg_code,
   input wire logic        route_ext_pin,
   input wire logic        route_avdd,
   input wire logic        route_avss,
   input wire logic        route_bandgap,
   input wire logic        route_charge_unit,
   input wire logic        route_temp_sensor,
   input wire logic        route_neg_avss,
   input wire logic        sel_invalid,
   // References and conversion clock
   input wire logic [2:0]  ref_request,
   input wire logic [2:0]  ref_enable,
   input wire logic        tad_tick
);
   logic up_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Outputs settle one edge after reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) up_reg <= 1'b0;
      else up_reg <= 1'b1;
   end

   a_read_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not idle");
   a_ext_pin: assert property (
      up_reg |-> route_ext_pin == (pos_code <= POS_LAST_PIN))
      else $error("pin route wrong");
   a_internal_src: assert property (
      up_reg |-> {route_avdd, route_avss, route_bandgap} == {pos_code ==
      POS_AVDD, pos_code == POS_AVSS, pos_code == POS_BANDGAP})
      else $error("internal route wrong");
   a_charge_temp: assert property (
      up_reg |-> {route_charge_unit, route_temp_sensor} ==
      {pos_code == POS_CHARGE, pos_code == POS_TEMP})
      else $error("charge route wrong");
   a_neg_ground: assert property (
      up_reg |-> route_neg_avss == (neg_code == NEG_AVSS))
      else $error("negative route wrong");
   a_reserved_code: assert property (
      up_reg && (pos_code inside {[5'h10:5'h1b]} || neg_code != NEG_AVSS)
      |-> sel_invalid)
      else $error("reserved code accepted");
   a_ref_follow: assert property (
      ref_request != 3'h0 |=>
      (ref_enable & $past(ref_request)) == $past(ref_request))
      else $error("request not honoured");
   a_tick_gap: assert property (
      tad_tick |=> !tad_tick)
      else $error("tick too close");
endmodule
`default_nettype wire

// [testbench/aiss_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module aiss_conv_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Command from the bench
   input  wire logic        go,
   input  wire logic [1:0]  ticks,
   input  wire logic [11:0] res,
   // Conversion clock from the block
   input  wire logic        tad_tick,
   // Result towards the block
   output var  logic        conv_done,
   output var  logic [11:0] conv_result
);
   logic       busy_reg;
   logic [1:0] cnt_reg;
   // Result toggles when idle so stale data shows
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
         cnt_reg <= 2'h0;
         conv_done <= 1'b0;
         conv_result <= 12'h000;
      end else if (go) begin
         busy_reg <= 1'b1;
         cnt_reg <= ticks;
         conv_result <= ~res;
      end else if (busy_reg && cnt_reg == 2'h0) begin
         busy_reg <= 1'b0;
         conv_done <= 1'b1;
         conv_result <= ~conv_result;
      end else begin
         conv_done <= 1'b0;
         if (busy_reg && tad_tick) cnt_reg <= cnt_reg - 2'h1;
         if (!busy_reg) conv_result <= ~conv_result;
      end
   end
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
   import aiss_pkg::*;
   ;
   logic        mclk, rst, reg_wr, reg_rd, conv_done, go, rd_d, m;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [11:0] conv_result, res, r;
   logic [2:0]  ref_request, ref_enable, ref_ready, neg_code;
   logic [4:0]  pos_code;
   logic [1:0]  ticks;
   logic        route_ext_pin, route_avdd, route_avss, route_bandgap;
   logic        route_charge_unit, route_temp_sensor, route_neg_avss;
   logic        has_result_buf, sel_invalid, charge_unit_connect;
   logic        tad_tick, scan_active, irq;
   logic [15:0] exp_q[$];
   logic [15:0] msk[7];
   logic [4:0]  seq[4];
   int          mismatches, tests_run, seed, i, n;

   always #12.5 mclk = ~mclk;

   aiss_regs #(.REF_STARTUP_COUNT(8)) u_aiss_regs (
      .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .conv_done, .conv_result, .ref_request, .pos_code, .neg_code,
      .route_ext_pin, .route_avdd, .route_avss, .route_bandgap,
      .route_charge_unit, .route_temp_sensor, .route_neg_avss,
      .has_result_buf, .sel_invalid, .charge_unit_connect, .ref_enable,
      .ref_ready, .tad_tick, .scan_active, .irq);
   aiss_conv_model u_aiss_conv_model (
      .mclk, .rst, .go, .ticks, .res, .tad_tick, .conv_done, .conv_result);

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] v);
      exp_q.push_back(v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic conv(input logic [11:0] v);
      int k;
      @(posedge mclk);
      go <= 1'b1;
      res <= v;
      ticks <= 2'($random(seed));
      @(posedge mclk);
      go <= 1'b0;
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (conv_done !== 1'b1 && k < 200);
      if (k >= 200) mismatches++;
   endtask
   task automatic gap(output int g);
      g = 0;
      do begin
         @(negedge mclk);
         g++;
      end while (tad_tick !== 1'b1 && g < 600);
   endtask
   task automatic idle(input int c);
      repeat (c) @(negedge mclk);
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Read data stand one cycle only
   always @(posedge mclk) rd_d <= reg_rd;
   always @(negedge mclk) begin
      if (rd_d === 1'b1) check(reg_rdata, exp_q.pop_front());
   end

   initial begin
      repeat (30000) @(posedge mclk);
      mismatches++;
      end_sim();
   end

   initial begin
      seed = 32'h25d336a4;
      mclk = 1'b0;
      rst = 1'b1;
      {reg_wr, reg_rd, go, ticks, res, ref_request} = '0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      msk = '{16'hffff, BGREF_MASK, HIT_MASK_FULL, SCANH_MASK, 16'hffff,
              CHGH_MASK_FULL, 16'hffff};
      seq = '{5'h01, 5'h04, 5'h18, 5'h01};
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 7; i++) rd(4'(i), RST_WORD);
      for (i = 0; i < 7; i++) begin
         d = 16'($random(seed));
         wr(4'(i), d);
         rd(4'(i), d & msk[i]);
         wr(4'(i), 16'h0000);
      end
      wr(4'hc, 16'hffff);
      rd(4'hc, 16'h0000);
      // Reference warm-up
      @(posedge mclk);
      ref_request <= 3'h2;
      idle(2);
      check(16'(ref_ready[1]), 16'h0000);
      idle(14);
      check(16'(ref_ready[1]), 16'h0001);
      wr(OFF_BGREF_EN, 16'h0004);
      idle(14);
      check(16'(ref_enable), 16'h0006);
      @(posedge mclk);
      ref_request <= 3'h6;
      idle(2);
      check(16'(ref_ready[2]), 16'h0001);
      // Every positive code
      wr(OFF_CHG_LOW, 16'h0004);
      for (i = 0; i < 32; i++) begin
         wr(OFF_SAMPLE_SEL, {8'h00, 3'(i), 5'(i)});
         idle(3);
         check(16'({route_ext_pin, route_avdd, route_avss, route_bandgap,
               route_charge_unit, route_temp_sensor, route_neg_avss,
               has_result_buf, sel_invalid, charge_unit_connect}),
               16'({i <= 13, i == 30, i == 29, i == 28, i == 15, i == 14,
               i % 8 == 0, i <= 13, (i > 15 && i < 28) || i % 8 != 0,
               i == 2}));
         check({8'h00, neg_code, pos_code}, {8'h00, 3'(i), 5'(i)});
      end
      wr(OFF_SAMPLE_SEL, 16'h0502);
      wr(OFF_CONTROL, 16'h0400);
      for (i = 0; i < 4; i++) begin
         idle(3);
         check({11'h000, pos_code}, i[0] ? 16'h0005 : 16'h0002);
         conv(12'h000);
      end
      // Each match condition
      wr(OFF_SAMPLE_SEL, 16'h0003);
      wr(OFF_THR_LOW, 16'h0100);
      wr(OFF_THR_HIGH, 16'h0200);
      for (i = 0; i < 8; i++) begin
         r = i[0] ? 12'h180 : 12'h050;
         m = i < 2 ? r < 12'h100 : i < 4 ? r > 12'h100 :
             i < 6 ? r >= 12'h100 && r <= 12'h200 : 1'b1;
         wr(OFF_CONTROL, {6'h00, 2'(i / 2), 8'h00});
         wr(OFF_HIT_LOW, 16'h0000);
         conv(r);
         rd(OFF_HIT_LOW, {12'h000, m, 3'h0});
      end
      idle(2);
      check(16'(irq), 16'h0000);
      wr(OFF_IRQ_MASK, 16'h0001);
      idle(2);
      check(16'(irq), 16'h0001);
      wr(OFF_HIT_LOW, 16'h0000);
      wr(OFF_IRQ_STAT, 16'h0007);
      idle(2);
      check(16'(irq), 16'h0000);
      rd(OFF_IRQ_STAT, 16'h0000);
      // Scan over channels 1, 4 and 24
      wr(OFF_CONTROL, 16'h0000);
      wr(OFF_SCAN_LOW, 16'h0012);
      wr(OFF_SCAN_HIGH, 16'h0100);
      idle(3);
      check({10'h000, scan_active, pos_code}, 16'h0003);
      wr(OFF_CONTROL, 16'h8000);
      for (i = 0; i < 4; i++) begin
         idle(3);
         check({11'h000, pos_code}, 16'(seq[i]));
         conv(12'h000);
      end
      rd(OFF_IRQ_STAT, 16'h0003);
      d = 16'($random(seed) & 7);
      wr(OFF_CONTROL, d);
      gap(n);
      gap(n);
      gap(n);
      check(16'(n), 16'(2 * (d + 1)));
      idle(4);
      end_sim();
   end
endmodule

bind aiss_regs aiss_regs_props #(.REF_STARTUP_COUNT(REF_STARTUP_COUNT))
   u_props (.mclk, .rst, .reg_rd, .reg_rdata, .pos_code, .neg_code,
   .route_ext_pin, .route_avdd, .route_avss, .route_bandgap,
   .route_charge_unit, .route_temp_sensor, .route_neg_avss, .sel_invalid,
   .ref_request, .ref_enable, .tad_tick);
`default_nettype wire
